// File: pkg/dac_mode_control_map.vh
// Register map, field positions, reset values and codes for the DAC mode registers.
// Assumes a 16-bit control word: bit 15 zero, bits 14:8 index, bits 7:0 data.
`ifndef DAC_MODE_CONTROL_MAP_VH
`define DAC_MODE_CONTROL_MAP_VH

// Register indices
`define REG_FILTER_GLOBAL 7'h09
`define REG_MODE_GLOBAL 7'h0a
`define REG_PHASE_INVERT 7'h0b
`define REG_OVER_ROLLOFF 7'h0c
`define REG_ATTEN_ZERO 7'h0d
`define REG_ZERO_STATUS 7'h0e

// Control word layout
`define WORD_ZERO_BIT 15
`define WORD_IDX_MSB 14
`define WORD_IDX_LSB 8
`define WORD_DATA_MSB 7

// Field positions
`define GLOBAL_ROLLOFF_BIT 5
`define ZERO_POLARITY_BIT 6
`define GLOBAL_PHASE_BIT 5
`define DEEMPH_RATE_LSB 3
`define DEEMPH_EN_BIT 0
`define OVERSAMPLE_BIT 7
`define ATTEN_MODE_BIT 7
`define ZERO_ROUTE_LSB 5

// Reset values
`define PHASE_INVERT_RST 8'hff
`define GROUP_ROLLOFF_RST 4'hf

// De-emphasis rate codes
`define DEEMPH_44K1 2'b00
`define DEEMPH_48K 2'b01
`define DEEMPH_32K 2'b10
`define DEEMPH_RSVD 2'b11

// Zero-flag routing codes
`define ROUTE_A 2'b00
`define ROUTE_B 2'b01
`define ROUTE_C 2'b10
`define ROUTE_D 2'b11

// System clock ratio codes and oversampling as log2 of factor
`define RATIO_128_192 2'b00
`define RATIO_256_384 2'b01
`define RATIO_512_UP 2'b10
`define OVS_LOG2_X16 3'h4
`define OVS_LOG2_X32 3'h5
`define OVS_LOG2_X64 3'h6

// Attenuator codes at and below which the output is muted
`define ATTEN_MUTE_FINE 8'h80
`define ATTEN_MUTE_WIDE 8'h9a

`endif

// File: rtl/spi_word_rx.v
// Receives 16-bit control words on the three-wire serial port.
// Assumes the latch line is low for a word, data taken on clock rises, MSB first.
`timescale 1ns/100ps
`default_nettype none
module spi_word_rx (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Serial pins
  input wire spi_latch_n,
  input wire spi_clk,
  input wire spi_data,
  // Word out
  output reg word_valid,
  output reg [15:0] word
);
  reg [2:0] lat_q;
  reg [2:0] clk_q;
  reg [1:0] dat_q;
  reg [15:0] shift_q;
  reg [4:0] count_q;
  wire clk_rise;
  wire lat_rise;
  assign clk_rise = clk_q[1] & ~clk_q[2];
  assign lat_rise = lat_q[1] & ~lat_q[2];

  always @(posedge core_clk) begin
    if (reset) begin
      lat_q <= 3'h7;
      clk_q <= 3'h0;
      dat_q <= 2'h0;
      shift_q <= 16'h0000;
      count_q <= 5'h00;
      word_valid <= 1'b0;
      word <= 16'h0000;
    end else begin
      lat_q <= {lat_q[1:0], spi_latch_n};
      clk_q <= {clk_q[1:0], spi_clk};
      dat_q <= {dat_q[0], spi_data};
      word_valid <= 1'b0;
      if (lat_rise) begin
        // Only a full 16-bit word is passed on
        if (count_q == 5'h10) begin
          word_valid <= 1'b1;
          word <= shift_q;
        end
        count_q <= 5'h00;
      end else if (~lat_q[1] && clk_rise) begin
        shift_q <= {shift_q[14:0], dat_q[1]};
        if (count_q != 5'h1f)
          count_q <= count_q + 5'h01;
      end
    end
  end
endmodule // spi_word_rx
`default_nettype wire

// File: rtl/dac_mode_control_registers.v
// Mode control registers of an eight-channel DAC, reached over SPI and I2C.
// Assumes zero-detect inputs on core_clk; pins are synchronised here.
`include "dac_mode_control_map.vh"
`timescale 1ns/100ps
`default_nettype none
module dac_mode_control_registers #(
  parameter [6:0] I2C_DEV_ADDR = 7'h4c // Arbitrary value
) (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Serial control port
  input wire spi_latch_n,
  input wire spi_clk,
  input wire spi_data,
  // I2C control port
  input wire i2c_scl,
  input wire i2c_sda_in,
  output wire i2c_sda_out,
  output wire i2c_sda_oe,
  // Device status
  input wire [1:0] sysclk_ratio,
  input wire [7:0] chan_zero,
  // Controls
  output reg deemph_all_enable,
  output reg [1:0] deemph_rate_sel,
  output reg deemph_rate_44k1,
  output reg deemph_rate_48k,
  output reg deemph_rate_32k,
  output reg [7:0] chan_phase_invert,
  output reg [3:0] group_rolloff_slow,
  output reg [2:0] oversample_log2,
  output reg atten_step_mode,
  output reg [7:0] atten_mute_code,
  output reg zero_flag_first,
  output reg zero_flag_second
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_ACK = 3'd2;
  localparam [2:0] ST_IDX = 3'd3;
  localparam [2:0] ST_WDATA = 3'd4;
  localparam [2:0] ST_RDATA = 3'd5;
  localparam [2:0] ST_RACK = 3'd6;

  reg [7:0] phase_q;
  reg [3:0] rolloff_q;
  reg glob_roll_q;
  reg zpol_q;
  reg gphase_q;
  reg [1:0] drate_q;
  reg demen_q;
  reg over_q;
  reg atten_q;
  reg [1:0] route_q;

  wire spi_valid;
  wire [15:0] spi_word;

  reg [2:0] scl_q;
  reg [2:0] sda_q;
  reg [2:0] state_q;
  reg [2:0] after_q;
  reg [3:0] bit_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg [6:0] idx_q;
  reg oe_q;
  reg i2c_wr_q;
  reg [7:0] i2c_wdata_q;

  wire scl_rise;
  wire scl_fall;
  wire i2c_start;
  wire i2c_stop;
  wire wr_en;
  wire [6:0] wr_idx;
  wire [7:0] wr_data;
  wire [7:0] rd_data;

  // Flag for one route: second selects the second flag
  function route_flag;
    input [1:0] route;
    input [7:0] z;
    input second;
    begin
      case (route)
        `ROUTE_A: route_flag = second ? z[1] : z[0];
        `ROUTE_B: route_flag = &z;
        `ROUTE_C: route_flag = second ? &z[5:0] : &z[7:6];
        default: route_flag = second ? &z[7:2] : &z[1:0];
      endcase
    end
  endfunction

  function [7:0] read_reg;
    input [6:0] idx;
    begin
      read_reg = 8'h00;
      if (idx == `REG_FILTER_GLOBAL)
        read_reg[`GLOBAL_ROLLOFF_BIT] = glob_roll_q;
      else if (idx == `REG_MODE_GLOBAL) begin
        read_reg[`ZERO_POLARITY_BIT] = zpol_q;
        read_reg[`GLOBAL_PHASE_BIT] = gphase_q;
        read_reg[`DEEMPH_RATE_LSB+1:`DEEMPH_RATE_LSB] = drate_q;
        read_reg[`DEEMPH_EN_BIT] = demen_q;
      end else if (idx == `REG_PHASE_INVERT)
        read_reg = phase_q;
      else if (idx == `REG_OVER_ROLLOFF)
        read_reg = {over_q, 3'b000, rolloff_q};
      else if (idx == `REG_ATTEN_ZERO)
        read_reg = {atten_q, route_q, 5'b00000};
      else if (idx == `REG_ZERO_STATUS)
        read_reg = chan_zero;
    end
  endfunction

  spi_word_rx u_spi (
    .core_clk(core_clk),
    .reset(reset),
    .spi_latch_n(spi_latch_n),
    .spi_clk(spi_clk),
    .spi_data(spi_data),
    .word_valid(spi_valid),
    .word(spi_word)
  );

  // Serial port wins a collision, even a word with bit 15 set; such words are otherwise dropped
  assign wr_en = (spi_valid & ~spi_word[`WORD_ZERO_BIT]) | i2c_wr_q;
  assign wr_idx = spi_valid ? spi_word[`WORD_IDX_MSB:`WORD_IDX_LSB] : idx_q;
  assign wr_data = spi_valid ? spi_word[`WORD_DATA_MSB:0] : i2c_wdata_q;
  assign rd_data = read_reg(idx_q);

  // Register bank
  always @(posedge core_clk) begin
    if (reset) begin
      phase_q <= `PHASE_INVERT_RST;
      rolloff_q <= `GROUP_ROLLOFF_RST;
      glob_roll_q <= 1'b0;
      zpol_q <= 1'b0;
      gphase_q <= 1'b0;
      drate_q <= `DEEMPH_44K1;
      demen_q <= 1'b0;
      over_q <= 1'b0;
      atten_q <= 1'b0;
      route_q <= `ROUTE_A;
    end else if (wr_en) begin
      if (wr_idx == `REG_FILTER_GLOBAL)
        glob_roll_q <= wr_data[`GLOBAL_ROLLOFF_BIT];
      else if (wr_idx == `REG_MODE_GLOBAL) begin
        zpol_q <= wr_data[`ZERO_POLARITY_BIT];
        gphase_q <= wr_data[`GLOBAL_PHASE_BIT];
        drate_q <= wr_data[`DEEMPH_RATE_LSB+1:`DEEMPH_RATE_LSB];
        demen_q <= wr_data[`DEEMPH_EN_BIT];
      end else if (wr_idx == `REG_PHASE_INVERT)
        phase_q <= wr_data;
      else if (wr_idx == `REG_OVER_ROLLOFF) begin
        over_q <= wr_data[`OVERSAMPLE_BIT];
        rolloff_q <= wr_data[3:0];
      end else if (wr_idx == `REG_ATTEN_ZERO) begin
        atten_q <= wr_data[`ATTEN_MODE_BIT];
        route_q <= wr_data[`ZERO_ROUTE_LSB+1:`ZERO_ROUTE_LSB];
      end
    end
  end

  // Derived controls, registered
  always @(posedge core_clk) begin
    if (reset) begin
      deemph_all_enable <= 1'b0;
      deemph_rate_sel <= `DEEMPH_44K1;
      deemph_rate_44k1 <= 1'b0;
      deemph_rate_48k <= 1'b0;
      deemph_rate_32k <= 1'b0;
      chan_phase_invert <= 8'h00;
      group_rolloff_slow <= 4'h0;
      oversample_log2 <= `OVS_LOG2_X64;
      atten_step_mode <= 1'b0;
      atten_mute_code <= `ATTEN_MUTE_FINE;
      zero_flag_first <= 1'b0;
      zero_flag_second <= 1'b0;
    end else begin
      // Reserved rate code leaves de-emphasis off
      deemph_all_enable <= demen_q & (drate_q != `DEEMPH_RSVD);
      deemph_rate_sel <= drate_q;
      deemph_rate_44k1 <= demen_q & (drate_q == `DEEMPH_44K1);
      deemph_rate_48k <= demen_q & (drate_q == `DEEMPH_48K);
      deemph_rate_32k <= demen_q & (drate_q == `DEEMPH_32K);
      chan_phase_invert <= gphase_q ? phase_q : 8'h00;
      group_rolloff_slow <= glob_roll_q ? rolloff_q : 4'h0;
      if (sysclk_ratio == `RATIO_128_192)
        oversample_log2 <= over_q ? `OVS_LOG2_X32 : `OVS_LOG2_X16;
      else if (sysclk_ratio == `RATIO_256_384)
        oversample_log2 <= over_q ? `OVS_LOG2_X64 : `OVS_LOG2_X32;
      else
        oversample_log2 <= over_q ? `OVS_LOG2_X64 + 3'h1 : `OVS_LOG2_X64;
      atten_step_mode <= atten_q;
      atten_mute_code <= atten_q ? `ATTEN_MUTE_WIDE : `ATTEN_MUTE_FINE;
      zero_flag_first <= route_flag(route_q, chan_zero, 1'b0) ^ zpol_q;
      zero_flag_second <= route_flag(route_q, chan_zero, 1'b1) ^ zpol_q;
    end
  end

  // I2C slave: index byte then data bytes; reads return the register at the current index
  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign i2c_start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign i2c_stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  assign i2c_sda_out = 1'b0;
  assign i2c_sda_oe = oe_q;

  always @(posedge core_clk) begin
    if (reset) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      state_q <= ST_IDLE;
      after_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      idx_q <= 7'h00;
      oe_q <= 1'b0;
      i2c_wr_q <= 1'b0;
      i2c_wdata_q <= 8'h00;
    end else begin
      scl_q <= {scl_q[1:0], i2c_scl};
      sda_q <= {sda_q[1:0], i2c_sda_in};
      i2c_wr_q <= 1'b0;
      if (i2c_start) begin
        state_q <= ST_ADDR;
        bit_q <= 4'h0;
        oe_q <= 1'b0;
      end else if (i2c_stop) begin
        state_q <= ST_IDLE;
        oe_q <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_IDX, ST_WDATA: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_q[1]};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              bit_q <= 4'h0;
              oe_q <= 1'b1;
              state_q <= ST_ACK;
              if (state_q == ST_ADDR) begin
                if (shift_q[7:1] == I2C_DEV_ADDR)
                  after_q <= shift_q[0] ? ST_RDATA : ST_IDX;
                else begin
                  oe_q <= 1'b0;
                  state_q <= ST_IDLE;
                end
              end else if (state_q == ST_IDX) begin
                if (!shift_q[7]) begin
                  idx_q <= shift_q[6:0];
                  after_q <= ST_WDATA;
                end else begin
                  oe_q <= 1'b0;
                  state_q <= ST_IDLE;
                end
              end else begin
                i2c_wr_q <= 1'b1;
                i2c_wdata_q <= shift_q;
                after_q <= ST_WDATA;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              state_q <= after_q;
              oe_q <= 1'b0;
              if (after_q == ST_RDATA) begin
                tx_q <= rd_data;
                oe_q <= ~rd_data[7];
                bit_q <= 4'h1;
              end
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (bit_q == 4'h8) begin
                oe_q <= 1'b0;
                state_q <= ST_RACK;
              end else begin
                oe_q <= ~tx_q[6];
                tx_q <= {tx_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise)
              state_q <= sda_q[1] ? ST_IDLE : ST_ACK;
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // dac_mode_control_registers
`default_nettype wire

// File: verification/dac_mode_props.sv
// Checker for the mode register outputs.
// Assumes a bind to the top module; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module dac_mode_props (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Pins
  input wire spi_latch_n,
  input wire i2c_scl,
  input wire i2c_sda_out,
  input wire i2c_sda_oe,
  input wire [1:0] sysclk_ratio,
  // Controls
  input wire deemph_all_enable,
  input wire [1:0] deemph_rate_sel,
  input wire deemph_rate_44k1,
  input wire deemph_rate_48k,
  input wire deemph_rate_32k,
  input wire [7:0] chan_phase_invert,
  input wire [3:0] group_rolloff_slow,
  input wire [2:0] oversample_log2,
  input wire atten_step_mode,
  input wire [7:0] atten_mute_code,
  input wire zero_flag_first,
  input wire zero_flag_second
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [1:0] ratio_q;
  wire [2:0] ovs_base = ratio_q == 2'b00 ? 3'h4 : ratio_q == 2'b01 ? 3'h5 : 3'h6;
  always @(posedge core_clk) ratio_q <= sysclk_ratio;
  a_rate_reserved: assert property (
    deemph_rate_sel == 2'b11 |-> !deemph_all_enable && !deemph_rate_44k1)
    else $error("reserved rate code active");
  a_rate_decode: assert property (
    {deemph_rate_32k, deemph_rate_48k, deemph_rate_44k1} ==
    (deemph_all_enable ? 3'b001 << deemph_rate_sel : 3'b000))
    else $error("rate flag mismatch");
  a_enable_flags: assert property (
    deemph_all_enable == (deemph_rate_44k1 | deemph_rate_48k | deemph_rate_32k))
    else $error("enable without rate");
  a_oversample_map: assert property (
    !$past(reset) |-> oversample_log2 - ovs_base <= 3'h1)
    else $error("oversampling off ratio");
  a_mute_code: assert property (
    atten_mute_code == (atten_step_mode ? 8'h9a : 8'h80))
    else $error("mute code mismatch");
  a_reset_values: assert property (
    $fell(reset) |-> chan_phase_invert == 8'h00 && group_rolloff_slow == 4'h0 &&
    oversample_log2 == 3'h6 && !zero_flag_first && !zero_flag_second && !atten_step_mode)
    else $error("bad reset state");
  a_sda_open_drain: assert property (
    !i2c_sda_out)
    else $error("data line driven high");
  a_sda_change_low: assert property (
    $changed(i2c_sda_oe) |-> !i2c_scl)
    else $error("data line moved while clock high");
  a_ctrl_hold: assert property (
    (!spi_latch_n && i2c_scl) [*8] |=>
    $stable({chan_phase_invert, group_rolloff_slow, atten_mute_code, deemph_rate_sel}))
    else $error("control changed mid word");
endmodule // dac_mode_props
`default_nettype wire

// File: verification/spi_host_model.sv
// Host side of the three-wire control port.
// Assumes calls on core clock falls; the device takes data on clock rises while latch is low.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  // Serial pins
  output logic spi_latch_n,
  output logic spi_clk,
  output logic spi_data
);
  initial begin
    spi_latch_n = 1'b1;
    spi_clk = 1'b0;
    spi_data = 1'b0;
  end
  // One word, MSB first, 800 ns bit clock; gap delays the latch fall by 100 ns per step
  task automatic send_word(input logic [15:0] w, input int gap);
    int i;
    #(200 + 100 * gap) spi_latch_n = 1'b0;
    for (i = 15; i >= 0; i--) begin
      spi_data = w[i];
      #400 spi_clk = 1'b1;
      #400 spi_clk = 1'b0;
    end
    #400 spi_latch_n = 1'b1;
    spi_data = ~w[0];
  endtask
endmodule // spi_host_model
`default_nettype wire

// File: verification/tb_dac_mode_control_registers.sv
// Self-checking bench for the mode registers over the serial and I2C ports.
// Drives the I2C port in the last test; a host model drives the serial pins.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin failures++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_dac_mode_control_registers;
  localparam logic [6:0] DEV_ADDR = 7'h35; // Arbitrary bus address
  logic core_clk, reset, i2c_scl, i2c_sda_host;
  logic [1:0] sysclk_ratio;
  logic [7:0] chan_zero, d, z;
  wire spi_latch_n, spi_clk, spi_data, i2c_sda_out, i2c_sda_oe;
  wire deemph_all_enable, deemph_rate_44k1, deemph_rate_48k, deemph_rate_32k;
  wire [1:0] deemph_rate_sel;
  wire [7:0] chan_phase_invert, atten_mute_code;
  wire [3:0] group_rolloff_slow;
  wire [2:0] oversample_log2;
  wire atten_step_mode, zero_flag_first, zero_flag_second;
  // Open-drain data line with pull-up
  wire i2c_sda_in = i2c_sda_host & ~i2c_sda_oe;
  logic [11:0] res;
  logic [2:0] acks;
  int failures, checks_done, cycles, i, j, r;
  logic [31:0] seed = 32'h7247;
  dac_mode_control_registers #(
    .I2C_DEV_ADDR(DEV_ADDR)
  ) DUT (
    .core_clk(core_clk),
    .reset(reset),
    .spi_latch_n(spi_latch_n),
    .spi_clk(spi_clk),
    .spi_data(spi_data),
    .i2c_scl(i2c_scl),
    .i2c_sda_in(i2c_sda_in),
    .i2c_sda_out(i2c_sda_out),
    .i2c_sda_oe(i2c_sda_oe),
    .sysclk_ratio(sysclk_ratio),
    .chan_zero(chan_zero),
    .deemph_all_enable(deemph_all_enable),
    .deemph_rate_sel(deemph_rate_sel),
    .deemph_rate_44k1(deemph_rate_44k1),
    .deemph_rate_48k(deemph_rate_48k),
    .deemph_rate_32k(deemph_rate_32k),
    .chan_phase_invert(chan_phase_invert),
    .group_rolloff_slow(group_rolloff_slow),
    .oversample_log2(oversample_log2),
    .atten_step_mode(atten_step_mode),
    .atten_mute_code(atten_mute_code),
    .zero_flag_first(zero_flag_first),
    .zero_flag_second(zero_flag_second)
  );
  spi_host_model host (
    .spi_latch_n(spi_latch_n),
    .spi_clk(spi_clk),
    .spi_data(spi_data)
  );
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [1:0] zf(input logic [1:0] rt, input logic [7:0] v, input logic p);
    logic a, b;
    case (rt)
      2'b00: begin a = v[0]; b = v[1]; end
      2'b01: begin a = &v; b = &v; end
      2'b10: begin a = &v[7:6]; b = &v[5:0]; end
      default: begin a = &v[1:0]; b = &v[7:2]; end
    endcase
    return {b, a} ^ {2{p}};
  endfunction
  task automatic wr(input logic [6:0] idx, input logic [7:0] dat);
    host.send_word({1'b0, idx, dat}, int'(rnd() % 3));
    repeat (10) @(negedge core_clk);
  endtask
  // One SCL pulse: drive b while low, sample the wire mid-high
  task automatic i2c_clk(input logic b, output logic s);
    @(negedge core_clk);
    i2c_sda_host = b;
    repeat (3) @(negedge core_clk);
    i2c_scl = 1'b1;
    repeat (2) @(negedge core_clk);
    s = i2c_sda_in;
    repeat (2) @(negedge core_clk);
    i2c_scl = 1'b0;
  endtask
  task automatic i2c_byte(input logic [7:0] b, output logic [7:0] q, output logic ack);
    int k;
    for (k = 7; k >= 0; k--) begin
      i2c_clk(b[k], q[k]);
    end
    i2c_clk(1'b1, ack);
  endtask
  // SDA moves to b while SCL is high: START for 0, STOP for 1
  task automatic i2c_cond(input logic b);
    @(negedge core_clk);
    i2c_sda_host = ~b;
    repeat (3) @(negedge core_clk);
    i2c_scl = 1'b1;
    repeat (4) @(negedge core_clk);
    i2c_sda_host = b;
    repeat (4) @(negedge core_clk);
    if (!b)
      i2c_scl = 1'b0;
  endtask
  task automatic i2c_write(input logic [6:0] idx, input logic [7:0] dat, output logic [2:0] a);
    logic [7:0] q;
    i2c_cond(1'b0);
    i2c_byte({DEV_ADDR, 1'b0}, q, a[2]);
    i2c_byte({1'b0, idx}, q, a[1]);
    i2c_byte(dat, q, a[0]);
    i2c_cond(1'b1);
  endtask
  // Acks of three bytes, level in the master's NACK slot, read byte
  task automatic i2c_read(input logic [6:0] idx, output logic [11:0] got);
    logic [7:0] q;
    logic a0, a1, a2, n;
    i2c_cond(1'b0);
    i2c_byte({DEV_ADDR, 1'b0}, q, a0);
    i2c_byte({1'b0, idx}, q, a1);
    i2c_cond(1'b0);
    i2c_byte({DEV_ADDR, 1'b1}, q, a2);
    i2c_byte(8'hff, q, n);
    i2c_cond(1'b1);
    got = {a0, a1, a2, n, q};
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    forever begin
      @(posedge core_clk);
      cycles++;
      if (cycles == 20000) begin
        failures++;
        end_of_test();
      end
    end
  end
  initial begin
    reset = 1'b1;
    sysclk_ratio = 2'b10;
    chan_zero = 8'h01;
    i2c_scl = 1'b1;
    i2c_sda_host = 1'b1;
    repeat (12) @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    `CHECK({chan_phase_invert, oversample_log2, zero_flag_second, zero_flag_first}, 13'h0019)
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      wr(7'h0a, {3'b000, i[1:0], 3'b001});
      `CHECK({deemph_rate_sel, deemph_rate_32k, deemph_rate_48k, deemph_rate_44k1, deemph_all_enable}, {i[1:0], i == 3 ? 4'h0 : {3'b001 << i, 1'b1}})
    end
    $display("rate test done");
    wr(7'h0a, 8'h20);
    `CHECK(chan_phase_invert, 8'hff)
    d = 8'(rnd());
    wr(7'h0b, d);
    `CHECK(chan_phase_invert, d)
    host.send_word({1'b1, 7'h0b, ~d}, 0);
    wr(7'h0e, ~d);
    `CHECK(chan_phase_invert, d)
    wr(7'h0a, 8'h00);
    `CHECK(chan_phase_invert, 8'h00)
    $display("phase test done");
    wr(7'h09, 8'h20);
    `CHECK(group_rolloff_slow, 4'hf)
    for (i = 0; i < 2; i++) begin
      wr(7'h0c, {i[0], 3'b000, d[3:0]});
      `CHECK(group_rolloff_slow, d[3:0])
      for (r = 0; r < 4; r++) begin
        @(negedge core_clk) sysclk_ratio = r[1:0];
        repeat (2) @(negedge core_clk);
        `CHECK(oversample_log2, 3'(r == 3 ? 6 + i : 4 + r + i))
      end
    end
    wr(7'h09, 8'h00);
    `CHECK(group_rolloff_slow, 4'h0)
    $display("filter test done");
    for (i = 0; i < 8; i++) begin
      d = 8'(rnd());
      wr(7'h0a, {1'b0, i[2], 6'b000000});
      wr(7'h0d, {d[0], i[1:0], 5'b00000});
      `CHECK({atten_step_mode, atten_mute_code}, {d[0], d[0] ? 8'h9a : 8'h80})
      for (j = 0; j < 6; j++) begin
        z = j == 0 ? 8'hff : j == 1 ? 8'hc0 : j == 2 ? 8'h3f : j == 3 ? 8'hfc : 8'(rnd());
        chan_zero = z;
        repeat (2) @(negedge core_clk);
        `CHECK({zero_flag_second, zero_flag_first}, zf(i[1:0], z, i[2]))
      end
    end
    $display("zero flag test done");
    i2c_write(7'h0b, d, acks);
    i2c_read(7'h0b, res);
    `CHECK({acks, res}, {3'b000, 4'b0001, d})
    i2c_read(7'h0e, res);
    `CHECK(res, {4'b0001, z})
    $display("i2c test done");
    end_of_test();
  end
endmodule // tb_dac_mode_control_registers
bind dac_mode_control_registers dac_mode_props props (
  .core_clk(core_clk),
  .reset(reset),
  .spi_latch_n(spi_latch_n),
  .i2c_scl(i2c_scl),
  .i2c_sda_out(i2c_sda_out),
  .i2c_sda_oe(i2c_sda_oe),
  .sysclk_ratio(sysclk_ratio),
  .deemph_all_enable(deemph_all_enable),
  .deemph_rate_sel(deemph_rate_sel),
  .deemph_rate_44k1(deemph_rate_44k1),
  .deemph_rate_48k(deemph_rate_48k),
  .deemph_rate_32k(deemph_rate_32k),
  .chan_phase_invert(chan_phase_invert),
  .group_rolloff_slow(group_rolloff_slow),
  .oversample_log2(oversample_log2),
  .atten_step_mode(atten_step_mode),
  .atten_mute_code(atten_mute_code),
  .zero_flag_first(zero_flag_first),
  .zero_flag_second(zero_flag_second)
);
`default_nettype wire
